// ### hw/edge_sync.sv
// Three-stage synchroniser with rising-edge pulse for a pin input
module edge_sync (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic resetn,
   // Pin and pulse
   input  wire logic pinIn,
   output logic      risePulse
);

   logic [2:0] syncQ;
   logic       levelQ;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         syncQ <= 3'h0;
      end
      else
      begin
         syncQ <= {syncQ[1:0], pinIn};
      end
   end

   // Level changes only once stages two and three agree
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         levelQ <= 1'b0;
      end
      else if (syncQ[1] == syncQ[2])
      begin
         levelQ <= syncQ[2];
      end
   end

   assign risePulse = (syncQ[1] == syncQ[2]) && syncQ[2] && !levelQ;

endmodule

// ### hw/pll_lock_detect.sv
// Lock detector with APB registers, pin routing and slip guard
module pll_lock_detect (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Phase comparator edges
   input  wire logic        refEdgePin,
   input  wire logic        fbEdgePin,
   // Serial port readback
   input  wire logic        serialRead,
   input  wire logic        serialReadData,
   // Outputs
   output logic             sdoPin,
   output logic             slipGuardBoost,
   output logic             prescaleDiv2,
   output logic             lockIndicator
);

   localparam int WIN_CNT_W_L = pll_lock_pkg::WIN_CNT_W;

   logic [23:0] ratioQ, cfgQ, prescQ, pdQ, routeQ;
   logic        refRise, fbRise;
   logic        lockQ, slipQ, rangeErrQ, sdoQ;
   logic [3:0]  cntQ;
   logic [1:0]  tickCntQ;
   logic [WIN_CNT_W_L-1:0] gapQ, ticksQ;
   pll_lock_pkg::win_state_t stateQ, stateD;
   logic        hit, miss, expire, waiting, tickEn;
   logic        ldEn, progMode;
   logic [2:0]  lockThr;
   logic [WIN_CNT_W_L-1:0] tickLimit, slipThr;
   logic        wrEn, setupRd, mapped;
   logic [4:0]  idx;
   logic        errOpenQ;
   logic [WIN_CNT_W_L-1:0] errQ;

   // ----------------------------------------
   // Function helpers
   // ----------------------------------------
   function automatic logic [23:0] mergeBytes(input logic [23:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
      logic [23:0] res;
      res = old;
      for (int b = 0; b < 3; b++)
      begin
         if (strb[b])
         begin
            res[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic ratioOk(input logic [23:0] r);
      logic [18:0] n;
      n = r[18:0];
      if (r[pll_lock_pkg::FRAC_MODE_BIT])
      begin
         return (n >= pll_lock_pkg::FRAC_N_MIN) && (n <= pll_lock_pkg::FRAC_N_MAX);
      end
      return (n >= pll_lock_pkg::INT_N_MIN) && (n <= pll_lock_pkg::INT_N_MAX);
   endfunction

   // ----------------------------------------
   // Edge inputs
   // ----------------------------------------
   edge_sync uRefSync (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .pinIn     (refEdgePin),
      .risePulse (refRise)
   );

   edge_sync uFbSync (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .pinIn     (fbEdgePin),
      .risePulse (fbRise)
   );

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   assign idx     = paddr[6:2];
   assign mapped  = (paddr[7] == 1'b0) && (paddr[1:0] == 2'b00) &&
                    (idx == pll_lock_pkg::IDX_FB_RATIO || idx == pll_lock_pkg::IDX_LOCK_CFG ||
                     idx == pll_lock_pkg::IDX_PRESCALE || idx == pll_lock_pkg::IDX_PD_CTRL ||
                     idx == pll_lock_pkg::IDX_PIN_ROUTE || idx == pll_lock_pkg::IDX_LOCK_STAT);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && (!mapped || (pwrite && idx == pll_lock_pkg::IDX_LOCK_STAT));
   assign wrEn    = psel && penable && pwrite && mapped;
   assign setupRd = psel && !penable && !pwrite;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         ratioQ <= pll_lock_pkg::REG_RESET;
         cfgQ   <= pll_lock_pkg::REG_RESET;
         prescQ <= pll_lock_pkg::REG_RESET;
         pdQ    <= pll_lock_pkg::REG_RESET;
         routeQ <= pll_lock_pkg::REG_RESET;
      end
      else if (wrEn)
      begin
         unique case (idx)
            pll_lock_pkg::IDX_FB_RATIO:  ratioQ <= mergeBytes(ratioQ, pwdata, pstrb);
            pll_lock_pkg::IDX_LOCK_CFG:  cfgQ   <= mergeBytes(cfgQ, pwdata, pstrb);
            pll_lock_pkg::IDX_PRESCALE:  prescQ <= mergeBytes(prescQ, pwdata, pstrb);
            pll_lock_pkg::IDX_PD_CTRL:   pdQ    <= mergeBytes(pdQ, pwdata, pstrb);
            pll_lock_pkg::IDX_PIN_ROUTE: routeQ <= mergeBytes(routeQ, pwdata, pstrb);
            default:                     ;
         endcase
      end
   end

   // Read data is captured in the setup cycle so the access phase needs no wait
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         prdata <= 32'h00000000;
      end
      else if (setupRd)
      begin
         prdata <= 32'h00000000;
         unique case (idx)
            pll_lock_pkg::IDX_FB_RATIO:  prdata[23:0] <= ratioQ;
            pll_lock_pkg::IDX_LOCK_CFG:  prdata[23:0] <= cfgQ;
            pll_lock_pkg::IDX_PRESCALE:  prdata[23:0] <= prescQ;
            pll_lock_pkg::IDX_PD_CTRL:   prdata[23:0] <= pdQ;
            pll_lock_pkg::IDX_PIN_ROUTE: prdata[23:0] <= routeQ;
            pll_lock_pkg::IDX_LOCK_STAT: prdata[3:0] <= {1'b0, rangeErrQ, lockQ, slipQ};
            default:                     ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rangeErrQ <= 1'b0;
      end
      else
      begin
         rangeErrQ <= !ratioOk(ratioQ);
      end
   end

   assign prescaleDiv2 = prescQ[pll_lock_pkg::PRESCALE_BIT];

   // ----------------------------------------
   // Window timing
   // ----------------------------------------
   // Enable and mode fields
   assign ldEn      = cfgQ[pll_lock_pkg::LD_EN_BIT];
   assign progMode  = cfgQ[pll_lock_pkg::LD_MODE_BIT];
   assign lockThr   = cfgQ[pll_lock_pkg::LD_THR_LSB +: 3];
   assign tickLimit = WIN_CNT_W_L'(1) << cfgQ[pll_lock_pkg::LD_DIV_LSB +: 3];
   assign waiting   = (stateQ != pll_lock_pkg::WIN_IDLE);

   // Timer tick divider set by speed field
   assign tickEn = (tickCntQ == cfgQ[pll_lock_pkg::LD_SPEED_LSB +: 2]);

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         tickCntQ <= 2'h0;
      end
      else if (!waiting || tickEn)
      begin
         tickCntQ <= 2'h0;
      end
      else
      begin
         tickCntQ <= tickCntQ + 2'h1;
      end
   end

   assign expire = progMode ? (ticksQ >= tickLimit) : (gapQ >= WIN_CNT_W_L'(pll_lock_pkg::FIXED_WIN_CYC));

   // Either edge may open the window
   always_comb
   begin
      stateD = stateQ;
      hit    = 1'b0;
      miss   = 1'b0;
      unique case (stateQ)
         pll_lock_pkg::WIN_IDLE:
         begin
            if (refRise && fbRise)
            begin
               hit = 1'b1;
            end
            else if (refRise)
            begin
               stateD = pll_lock_pkg::WIN_WAIT_FB;
            end
            else if (fbRise)
            begin
               stateD = pll_lock_pkg::WIN_WAIT_REF;
            end
         end
         pll_lock_pkg::WIN_WAIT_FB:
         begin
            if (fbRise)
            begin
               hit    = 1'b1;
               stateD = pll_lock_pkg::WIN_IDLE;
            end
            else if (expire || refRise)
            begin
               miss   = 1'b1;
               stateD = refRise ? pll_lock_pkg::WIN_WAIT_FB : pll_lock_pkg::WIN_IDLE;
            end
         end
         pll_lock_pkg::WIN_WAIT_REF:
         begin
            if (refRise)
            begin
               hit    = 1'b1;
               stateD = pll_lock_pkg::WIN_IDLE;
            end
            else if (expire || fbRise)
            begin
               miss   = 1'b1;
               stateD = fbRise ? pll_lock_pkg::WIN_WAIT_REF : pll_lock_pkg::WIN_IDLE;
            end
         end
         default:
         begin
            stateD = pll_lock_pkg::WIN_IDLE;
         end
      endcase
      if (!ldEn)
      begin
         stateD = pll_lock_pkg::WIN_IDLE;
         hit    = 1'b0;
         miss   = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         stateQ <= pll_lock_pkg::WIN_IDLE;
         gapQ   <= '0;
         ticksQ <= '0;
      end
      else
      begin
         stateQ <= stateD;
         if (stateD != stateQ || miss || !waiting)
         begin
            gapQ   <= '0;
            ticksQ <= '0;
         end
         else
         begin
            if (gapQ != '1)
            begin
               gapQ <= gapQ + WIN_CNT_W_L'(1);
            end
            if (tickEn && ticksQ != '1)
            begin
               ticksQ <= ticksQ + WIN_CNT_W_L'(1);
            end
         end
      end
   end

   // ----------------------------------------
   // Lock counter
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         cntQ  <= 4'h0;
         lockQ <= 1'b0;
      end
      else if (!ldEn)
      begin
         cntQ  <= 4'h0;
         lockQ <= 1'b0;
      end
      else if (miss)
      begin
         cntQ  <= 4'h0;
         lockQ <= 1'b0;
      end
      else if (hit)
      begin
         if (cntQ != 4'(pll_lock_pkg::LOCK_CNT_MAX))
         begin
            cntQ <= cntQ + 4'h1;
         end
         if ((cntQ + 4'h1) >= {1'b0, lockThr})
         begin
            lockQ <= 1'b1;
         end
      end
   end

   assign lockIndicator = lockQ;

   // ----------------------------------------
   // Slip guard
   // ----------------------------------------
   always_comb
   begin
      unique case (pdQ[pll_lock_pkg::SLIP_THR_LSB +: 2])
         2'h0:    slipThr = pll_lock_pkg::SLIP_THR0;
         2'h1:    slipThr = pll_lock_pkg::SLIP_THR1;
         2'h2:    slipThr = pll_lock_pkg::SLIP_THR2;
         default: slipThr = pll_lock_pkg::SLIP_THR3;
      endcase
   end

   // Phase error runs from one lone edge to the next, past window expiry
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         errOpenQ <= 1'b0;
         errQ     <= '0;
      end
      else if (!ldEn || (refRise && fbRise))
      begin
         errOpenQ <= 1'b0;
         errQ     <= '0;
      end
      else if (refRise || fbRise)
      begin
         errOpenQ <= !errOpenQ;
         errQ     <= '0;
      end
      else if (errOpenQ && errQ != '1)
      begin
         errQ <= errQ + WIN_CNT_W_L'(1);
      end
   end

   // Boost while phase error is large
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         slipQ <= 1'b0;
      end
      else
      begin
         slipQ <= errOpenQ && (errQ >= slipThr);
      end
   end

   assign slipGuardBoost = slipQ;

   // ----------------------------------------
   // Shared output pin
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         sdoQ <= 1'b0;
      end
      // Lock flag routing, forced wins over readback
      else if (routeQ[pll_lock_pkg::ROUTE_EN_BIT] &&
               routeQ[pll_lock_pkg::ROUTE_SEL_LSB +: 5] == pll_lock_pkg::ROUTE_SEL_LOCK &&
               (routeQ[pll_lock_pkg::ROUTE_FORCE_BIT] || !serialRead))
      begin
         sdoQ <= lockQ;
      end
      else
      begin
         sdoQ <= serialRead ? serialReadData : 1'b0;
      end
   end

   assign sdoPin = sdoQ;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   lockEnable_a: assert property (!ldEn |=> !lockQ && cntQ == 4'h0)
      else $error("lock held while detector disabled");
   statusRead_a: assert property (setupRd && idx == pll_lock_pkg::IDX_LOCK_STAT |=> prdata[1] == $past(lockQ))
      else $error("status bit differs from lock state");
   hitCount_a: assert property (ldEn && hit && cntQ < 4'h8 |=> cntQ == $past(cntQ) + 4'h1)
      else $error("hit did not advance count");
   lockThreshold_a: assert property (lockQ |-> cntQ >= {1'b0, lockThr} && cntQ != 4'h0)
      else $error("lock without reaching threshold");
   missDrop_a: assert property (miss |=> !lockQ && cntQ == 4'h0)
      else $error("miss did not clear lock");
   fixedWindow_a: assert property (ldEn && !progMode && waiting && gapQ >= 10'h001 |-> miss || hit)
      else $error("fixed window overran");
   progWindow_a: assert property (ldEn && progMode && waiting && !refRise && !fbRise && ticksQ >= tickLimit |-> miss)
      else $error("programmable window did not close");
   pairHit_a: assert property (ldEn && stateQ == pll_lock_pkg::WIN_IDLE && refRise && fbRise |-> hit)
      else $error("coincident edges not counted");
   pinForced_a: assert property (routeQ[7] && routeQ[6] && routeQ[4:0] == 5'h01 |=> sdoPin == $past(lockQ))
      else $error("forced pin lost lock flag");
   pinRead_a: assert property (routeQ[7] && !routeQ[6] && serialRead ##1 serialRead |-> sdoPin == $past(serialReadData))
      else $error("readback not on pin");
   rangeFlag_a: assert property (ratioQ[19] && ratioQ[18:0] < 19'd20 |=> rangeErrQ)
      else $error("fractional ratio below range not flagged");
   slipBoost_a: assert property (errOpenQ && errQ >= slipThr && ldEn |=> slipQ)
      else $error("slip guard failed to boost");

   lockSeen_c:   cover property (!lockQ ##1 lockQ);
   missLoss_c:   cover property (lockQ ##1 miss);
   progLock_c:   cover property (progMode && hit && lockQ);
   pinReadback_c: cover property (routeQ[7] && serialRead);

endmodule

// ### shared/pll_lock_pkg.sv
// Constants, register map and field layout of the PLL lock-detect block
//
// Operation
// - Fractional divider ratio spans 20 to 524283
// - Integer divider ratio spans 16 to 524287
// - Detector runs only while enable bit set
// - Status bit one reads lock state
// - Edge pair tested within window, either leading
// - Hits count up; lock at threshold
// - One miss clears count, drops lock
// - Mode bit low gives 10 ns window; code uses one 20 ns clock cycle
// - Mode bit high gives programmable window
// - Speed and divide fields select window size
// - Routing bits put lock flag on pin
// - Pin high when locked, low otherwise
// - Serial read borrows pin, then returns
// - Force bit keeps lock flag, no readback
// - Slip guard boosts gain past threshold
package pll_lock_pkg;

   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int FIXED_WIN_NS  = 10;
   // Longest time: round down, but never below one cycle
   localparam int FIXED_WIN_CYC = (FIXED_WIN_NS / CLK_PERIOD_NS) < 1 ? 1 : (FIXED_WIN_NS / CLK_PERIOD_NS);
   localparam int WIN_CNT_W     = 10;
   localparam int LOCK_CNT_MAX  = 8;

   // ----------------------------------------
   // Divider ratio limits
   // ----------------------------------------
   localparam logic [18:0] FRAC_N_MIN = 19'd20;
   localparam logic [18:0] FRAC_N_MAX = 19'd524283;
   localparam logic [18:0] INT_N_MIN  = 19'd16;
   localparam logic [18:0] INT_N_MAX  = 19'd524287;

   // ----------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------
   localparam logic [4:0] IDX_FB_RATIO   = 5'h03;
   localparam logic [4:0] IDX_LOCK_CFG   = 5'h07;
   localparam logic [4:0] IDX_PRESCALE   = 5'h08;
   localparam logic [4:0] IDX_PD_CTRL    = 5'h0B;
   localparam logic [4:0] IDX_PIN_ROUTE  = 5'h0F;
   localparam logic [4:0] IDX_LOCK_STAT  = 5'h12;
   localparam logic [23:0] REG_RESET     = 24'h000000;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int LD_THR_LSB      = 0;
   localparam int LD_EN_BIT       = 3;
   localparam int LD_MODE_BIT     = 6;
   localparam int LD_DIV_LSB      = 7;
   localparam int LD_SPEED_LSB    = 10;
   localparam int PRESCALE_BIT    = 19;
   localparam int SLIP_THR_LSB    = 7;
   localparam int ROUTE_SEL_LSB   = 0;
   localparam int ROUTE_FORCE_BIT = 6;
   localparam int ROUTE_EN_BIT    = 7;
   localparam int FRAC_MODE_BIT   = 19;
   localparam logic [4:0] ROUTE_SEL_LOCK = 5'h01;
   localparam int STAT_SLIP_BIT   = 0;
   localparam int STAT_LOCK_BIT   = 1;
   localparam int STAT_RANGE_BIT  = 2;

   // Slip guard thresholds in cycles of phase error
   localparam logic [WIN_CNT_W-1:0] SLIP_THR0 = 10'h004;
   localparam logic [WIN_CNT_W-1:0] SLIP_THR1 = 10'h008;
   localparam logic [WIN_CNT_W-1:0] SLIP_THR2 = 10'h010;
   localparam logic [WIN_CNT_W-1:0] SLIP_THR3 = 10'h020;

   typedef enum logic [1:0] {WIN_IDLE, WIN_WAIT_FB, WIN_WAIT_REF} win_state_t;

endpackage

// ### testbench/edge_partner.sv
// Behavioural source of divided reference and feedback edges
module edge_partner (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   // Control from the bench
   input  wire logic       run,
   input  wire logic [3:0] skew,
   // Edges towards the detector
   output logic            refEdgePin,
   output logic            fbEdgePin
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0] phase_q;
   logic [3:0] fbPhase;

   // ----------------------------------------
   // Comparison period
   // ----------------------------------------
   // Sixteen-clock comparison period
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         phase_q <= 4'h0;
      else if (!run)
         phase_q <= 4'h0;
      else
         phase_q <= phase_q + 4'h1;
   end

   // Feedback copy delayed by skew; wraps so fb may also lead
   assign fbPhase = phase_q - skew;
   assign refEdgePin = run & ~phase_q[3];
   assign fbEdgePin = run & ~fbPhase[3];
endmodule

// ### testbench/tb.sv
// Self-checking bench of the lock detector
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [7:0] A_FB = {1'b0, pll_lock_pkg::IDX_FB_RATIO, 2'b00};
   localparam logic [7:0] A_CFG = {1'b0, pll_lock_pkg::IDX_LOCK_CFG, 2'b00};
   localparam logic [7:0] A_PRE = {1'b0, pll_lock_pkg::IDX_PRESCALE, 2'b00};
   localparam logic [7:0] A_PD = {1'b0, pll_lock_pkg::IDX_PD_CTRL, 2'b00};
   localparam logic [7:0] A_PIN = {1'b0, pll_lock_pkg::IDX_PIN_ROUTE, 2'b00};
   localparam logic [7:0] A_ST = {1'b0, pll_lock_pkg::IDX_LOCK_STAT, 2'b00};

   logic        clk_sys = 1'b0;
   logic        resetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        refEdgePin;
   logic        fbEdgePin;
   logic        serialRead = 1'b0;
   logic        serialReadData = 1'b0;
   logic        sdoPin;
   logic        slipGuardBoost;
   logic        prescaleDiv2;
   logic        lockIndicator;
   logic        run = 1'b0;
   logic [3:0]  skew = 4'h0;
   logic [31:0] rd;
   logic        er;
   int          failures = 0;
   int          checks = 0;
   int          cycles = 0;
   int          boostCnt = 0;
   int          b0;

   always #10 clk_sys = ~clk_sys;

   pll_lock_detect DUT (
      .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .refEdgePin(refEdgePin), .fbEdgePin(fbEdgePin),
      .serialRead(serialRead), .serialReadData(serialReadData),
      .sdoPin(sdoPin), .slipGuardBoost(slipGuardBoost),
      .prescaleDiv2(prescaleDiv2), .lockIndicator(lockIndicator)
   );

   edge_partner partner (
      .clk_sys(clk_sys), .resetn(resetn), .run(run), .skew(skew),
      .refEdgePin(refEdgePin), .fbEdgePin(fbEdgePin)
   );

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic end_of_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Timeout well above the whole sequence
   always @(posedge clk_sys)
   begin
      cycles++;
      if (slipGuardBoost === 1'b1)
         boostCnt++;
      if (cycles == 5000)
      begin
         failures++;
         end_of_test();
      end
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Edge first so a release is never overwritten in the same step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
         @(posedge clk_sys);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic lk(input logic e);
      @(negedge clk_sys);
      chk("lockIndicator", {31'h0, e}, {31'h0, lockIndicator});
   endtask

   task automatic rng(input logic [31:0] v, input logic e);
      apb(1'b1, A_FB, v);
      apb(1'b0, A_ST, 32'h0);
      chk("ratioRange", {31'h0, e}, {31'h0, rd[2]});
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial
   begin
      cyc(5);
      resetn <= 1'b1;
      lk(1'b0);
      apb(1'b0, A_ST, 32'h0);
      chk("status", 32'h00000004, rd);
      apb(1'b1, A_ST, 32'h1);
      chk("roWriteErr", 32'h1, {31'h0, er});
      apb(1'b0, 8'h40, 32'h0);
      chk("unmappedErr", 32'h1, {31'h0, er});
      rng(32'h0000000F, 1'b1);
      rng(32'h00000010, 1'b0);
      rng(32'h00080013, 1'b1);
      rng(32'h00080014, 1'b0);
      // Host sets prescaler for the 8 GHz case
      apb(1'b1, A_PRE, 32'h00080000);
      apb(1'b0, A_PRE, 32'h0);
      chk("prescaleReg", 32'h00080000, rd);
      chk("prescaleDiv2", 32'h1, {31'h0, prescaleDiv2});
      apb(1'b1, A_CFG, 32'h0000000B);
      apb(1'b1, A_PIN, 32'h00000081);
      run <= 1'b1;
      cyc(28);
      lk(1'b0);
      cyc(20);
      lk(1'b1);
      apb(1'b0, A_ST, 32'h0);
      chk("statusLock", 32'h1, {31'h0, rd[1]});
      chk("sdoLock", 32'h1, {31'h0, sdoPin});
      serialRead <= 1'b1;
      cyc(3);
      @(negedge clk_sys);
      chk("sdoRead", 32'h0, {31'h0, sdoPin});
      cyc(1);
      serialRead <= 1'b0;
      cyc(3);
      @(negedge clk_sys);
      chk("sdoBack", 32'h1, {31'h0, sdoPin});
      apb(1'b1, A_PIN, 32'h000000C1);
      serialRead <= 1'b1;
      cyc(3);
      @(negedge clk_sys);
      chk("sdoForce", 32'h1, {31'h0, sdoPin});
      cyc(1);
      serialRead <= 1'b0;
      apb(1'b1, A_PD, 32'h00000180);
      skew <= 4'h8;
      cyc(16);
      lk(1'b0);
      chk("sdoUnlock", 32'h0, {31'h0, sdoPin});
      b0 = boostCnt;
      cyc(32);
      chk("boostHighThr", b0, boostCnt);
      apb(1'b1, A_PD, 32'h00000000);
      b0 = boostCnt;
      cyc(32);
      chk("boostLowThr", 32'h1, {31'h0, boostCnt > b0});
      // Feedback one clock ahead of reference
      skew <= 4'hF;
      cyc(64);
      lk(1'b1);
      skew <= 4'h3;
      cyc(48);
      lk(1'b0);
      // Divide 2 at fastest speed covers a three-clock gap
      apb(1'b1, A_CFG, 32'h0000014B);
      cyc(64);
      lk(1'b1);
      apb(1'b1, A_CFG, 32'h00000143);
      cyc(1);
      lk(1'b0);
      apb(1'b0, A_ST, 32'h0);
      chk("statusOff", 32'h0, {31'h0, rd[1]});
      apb(1'b1, A_CFG, 32'h0000004B);
      cyc(64);
      lk(1'b0);
      end_of_test();
   end
endmodule
